//--- effecter_enable_defs.vh
`ifndef EFFECTER_ENABLE_DEFS_VH
`define EFFECTER_ENABLE_DEFS_VH

// ==========================================================
// Handle values
`define HANDLE_RSVD_LOW 16'h0000
`define HANDLE_RSVD_HIGH 16'hffff

// ==========================================================
// Request layout
`define HDR_BYTES 5'h03
`define BYTE_HANDLE_LSB 5'h00
`define BYTE_HANDLE_MSB 5'h01
`define BYTE_SET_COUNT 5'h02
`define SET_COUNT_MIN 8'h01
`define SET_COUNT_MAX 8'h08
`define BYTE_CNT_SAT 5'h1f

// ==========================================================
// Operational state codes
`define OP_ENABLED 8'h01
`define OP_DISABLED 8'h02
`define OP_UNAVAILABLE 8'h03

// ==========================================================
// Event report control codes
`define EV_EVENTS_ON 8'h00
`define EV_EVENTS_OFF 8'h01
`define EV_KEEP_CURRENT 8'hff

// ==========================================================
// Result codes
`define RC_SUCCESS 8'h00
`define RC_INVALID_DATA 8'h02
`define RC_UNKNOWN_HANDLE 8'h80

// ==========================================================
// Reset values
`define OP_STATE_RESET 8'h01
`define EVENT_EN_RESET 1'b0
`define EFF_STATE_RESET 8'h00

`endif

//--- op_record_buffer.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Byte store of the operation records, word read port
module op_record_buffer #(
    parameter DEPTH = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // Byte write port
    input wire wr_en_i,
    input wire [3:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    // Record read port
    input wire rd_en_i,
    input wire [2:0] rd_idx_i,
    output reg [15:0] rd_data_o
);

    reg [7:0] mem [0:2*DEPTH-1];

    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_en_i) begin
            rd_data_o <= {mem[{rd_idx_i, 1'b1}], mem[{rd_idx_i, 1'b0}]};
        end
    end

endmodule

`default_nettype wire

//--- state_effecter_enable_cmd.v
`timescale 1ns/1ps
`default_nettype none
`include "effecter_enable_defs.vh"

// Contract
// - The request opens with a 16-bit effecter handle, and 0x0000 and 0xffff never name an effecter.
// - An 8-bit set count follows the handle and is legal only from 0x01 to 0x08.
// - Effecters under one handle are reached by offsets 0 to 7, eight at most.
// - One two-byte record per counted effecter follows, op state byte then event control byte.
// - The op state byte selects enabled, disabled (code 2) or unavailable.
// - Accepted op state codes carry the same values as those the state query reports.
// - The event control byte turns event generation on or off for that effecter.
// - Event control 0xff leaves the effecter's event setting as it is.
// - Every request gets an 8-bit result code, 0x80 when the handle names no effecter; the code answers a request under 3 bytes with 0x02 whatever its handle.
// - A disabled effecter refuses any update of its state.
// - An effecter with a default state returns to it when it becomes disabled.
module state_effecter_enable_cmd #(
    parameter [7:0] NUM_EFFECTERS = 8'h08
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // Configuration
    input wire [15:0] own_handle_i,
    input wire [7:0] has_default_i,
    input wire [63:0] default_state_i,
    // Request byte stream
    input wire rx_valid_i,
    input wire [7:0] rx_data_i,
    input wire rx_last_i,
    output reg rx_ready_o,
    // Result
    output reg result_valid_o,
    output reg [7:0] result_code_o,
    // Effecter state write port
    input wire write_req_i,
    input wire [2:0] write_offset_i,
    input wire [7:0] write_state_i,
    output reg write_done_o,
    output reg write_refused_o,
    // Effecter status
    output reg [63:0] op_state_o,
    output reg [7:0] event_enable_o,
    output reg [63:0] effecter_state_o,
    output reg [7:0] default_restore_o
);

    // ==========================================================
    // Decoding functions
    function op_code_ok;
        input [7:0] code;
        begin
            op_code_ok = (code == `OP_ENABLED) || (code == `OP_DISABLED) ||
                (code == `OP_UNAVAILABLE);
        end
    endfunction

    function ev_code_ok;
        input [7:0] code;
        begin
            ev_code_ok = (code == `EV_EVENTS_ON) || (code == `EV_EVENTS_OFF) ||
                (code == `EV_KEEP_CURRENT);
        end
    endfunction

    // ==========================================================
    // Sequencer states
    localparam [2:0] ST_RECV = 3'h0;
    localparam [2:0] ST_CHECK = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_APPLY = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;

    reg [2:0] state_r;
    reg [4:0] byte_cnt_r;
    reg [15:0] handle_r;
    reg [7:0] set_count_r;
    reg bad_rec_r;
    reg [2:0] idx_r;

    wire take_byte = rx_valid_i && rx_ready_o;
    wire [4:0] rec_pos = byte_cnt_r - `HDR_BYTES;
    wire in_records = (byte_cnt_r >= `HDR_BYTES) && (rec_pos < 5'h10);
    wire [8:0] exp_len = {set_count_r, 1'b0} + {4'h0, `HDR_BYTES};
    wire handle_bad = (handle_r == `HANDLE_RSVD_LOW) || (handle_r == `HANDLE_RSVD_HIGH) ||
        (handle_r != own_handle_i);
    wire count_bad = (set_count_r < `SET_COUNT_MIN) || (set_count_r > `SET_COUNT_MAX) ||
        (set_count_r > NUM_EFFECTERS);
    wire len_bad = (exp_len != {4'h0, byte_cnt_r});
    wire [15:0] rec_data;
    wire [7:0] rec_op = rec_data[7:0];
    wire [7:0] rec_ev = rec_data[15:8];
    wire [7:0] last_idx = set_count_r - 8'h01;

    // ==========================================================
    // Record store
    op_record_buffer #(
        .DEPTH(8)
    ) u_records (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(take_byte && in_records),
        .wr_addr_i(rec_pos[3:0]),
        .wr_data_i(rx_data_i),
        .rd_en_i(state_r == ST_READ),
        .rd_idx_i(idx_r),
        .rd_data_o(rec_data)
    );

    // ==========================================================
    // Request sequencer
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_RECV;
            byte_cnt_r <= 5'h00;
            handle_r <= 16'h0000;
            set_count_r <= 8'h00;
            bad_rec_r <= 1'b0;
            idx_r <= 3'h0;
            rx_ready_o <= 1'b1;
            result_valid_o <= 1'b0;
            result_code_o <= `RC_SUCCESS;
        end else begin
            result_valid_o <= 1'b0;
            case (state_r)
                ST_RECV: begin
                    if (take_byte) begin
                        if (byte_cnt_r != `BYTE_CNT_SAT) begin
                            byte_cnt_r <= byte_cnt_r + 5'h01;
                        end
                        if (byte_cnt_r == `BYTE_HANDLE_LSB) begin
                            handle_r[7:0] <= rx_data_i;
                        end
                        if (byte_cnt_r == `BYTE_HANDLE_MSB) begin
                            handle_r[15:8] <= rx_data_i;
                        end
                        if (byte_cnt_r == `BYTE_SET_COUNT) begin
                            set_count_r <= rx_data_i;
                        end
                        if (in_records && !rec_pos[0] && !op_code_ok(rx_data_i)) begin
                            bad_rec_r <= 1'b1;
                        end
                        if (in_records && rec_pos[0] && !ev_code_ok(rx_data_i)) begin
                            bad_rec_r <= 1'b1;
                        end
                        if (rx_last_i) begin
                            rx_ready_o <= 1'b0;
                            state_r <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    idx_r <= 3'h0;
                    if (byte_cnt_r < `HDR_BYTES) begin
                        result_code_o <= `RC_INVALID_DATA;
                        state_r <= ST_DONE;
                    end else if (handle_bad) begin
                        result_code_o <= `RC_UNKNOWN_HANDLE;
                        state_r <= ST_DONE;
                    end else if (count_bad || len_bad || bad_rec_r) begin
                        result_code_o <= `RC_INVALID_DATA;
                        state_r <= ST_DONE;
                    end else begin
                        state_r <= ST_READ;
                    end
                end
                ST_READ: begin
                    state_r <= ST_APPLY;
                end
                ST_APPLY: begin
                    if ({5'h00, idx_r} == last_idx) begin
                        result_code_o <= `RC_SUCCESS;
                        state_r <= ST_DONE;
                    end else begin
                        idx_r <= idx_r + 3'h1;
                        state_r <= ST_READ;
                    end
                end
                ST_DONE: begin
                    result_valid_o <= 1'b1;
                    byte_cnt_r <= 5'h00;
                    bad_rec_r <= 1'b0;
                    rx_ready_o <= 1'b1;
                    state_r <= ST_RECV;
                end
                default: begin
                    state_r <= ST_RECV;
                    rx_ready_o <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Effecter state and settings
    wire [5:0] apply_base = {idx_r, 3'b000};
    wire [5:0] write_base = {write_offset_i, 3'b000};
    wire apply_now = (state_r == ST_APPLY);
    wire goes_disabled = (rec_op == `OP_DISABLED) &&
        (op_state_o[apply_base +: 8] != `OP_DISABLED);

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_state_o <= {8{`OP_STATE_RESET}};
            event_enable_o <= {8{`EVENT_EN_RESET}};
            effecter_state_o <= {8{`EFF_STATE_RESET}};
            default_restore_o <= 8'h00;
            write_done_o <= 1'b0;
            write_refused_o <= 1'b0;
        end else begin
            default_restore_o <= 8'h00;
            write_done_o <= 1'b0;
            write_refused_o <= 1'b0;
            if (write_req_i) begin
                if (op_state_o[write_base +: 8] == `OP_DISABLED) begin
                    write_refused_o <= 1'b1;
                end else begin
                    effecter_state_o[write_base +: 8] <= write_state_i;
                    write_done_o <= 1'b1;
                end
            end
            if (apply_now) begin
                op_state_o[apply_base +: 8] <= rec_op;
                if (rec_ev == `EV_EVENTS_ON) begin
                    event_enable_o[idx_r] <= 1'b1;
                end else if (rec_ev == `EV_EVENTS_OFF) begin
                    event_enable_o[idx_r] <= 1'b0;
                end
                // Keep-current code leaves the bit untouched
                if (goes_disabled && has_default_i[idx_r]) begin
                    effecter_state_o[apply_base +: 8] <= default_state_i[apply_base +: 8];
                    default_restore_o[idx_r] <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- state_effecter_enable_cmd_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module state_effecter_enable_cmd_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Watched ports
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic rx_ready_o,
    input wire logic result_valid_o,
    input wire logic [7:0] result_code_o,
    input wire logic write_req_i,
    input wire logic [2:0] write_offset_i,
    input wire logic write_done_o,
    input wire logic write_refused_o,
    input wire logic [63:0] op_state_o,
    input wire logic [7:0] event_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic last_taken = rx_valid_i && rx_ready_o && rx_last_i;
    a_result_pulse: assert property (result_valid_o |=> !result_valid_o)
        else $error("result pulse too long");
    a_ready_returns: assert property ($rose(result_valid_o) |-> rx_ready_o)
        else $error("ready not back with result");
    a_busy_after_last: assert property (last_taken |=> !rx_ready_o)
        else $error("byte taken while busy");
    a_answer_bound: assert property (last_taken |-> ##[2:19] result_valid_o)
        else $error("no result code");
    a_write_answer: assert property (write_req_i |=> write_done_o != write_refused_o)
        else $error("write not answered once");
    a_refuse_disabled: assert property (write_req_i &&
        op_state_o[write_offset_i*8 +: 8] == 8'h02 |=> write_refused_o)
        else $error("disabled write accepted");
    a_answer_cause: assert property ((write_done_o || write_refused_o) |->
        $past(write_req_i)) else $error("write answer without request");
    a_code_hold: assert property ($changed(result_code_o) |=> result_valid_o)
        else $error("result code moved without result");
    a_change_success: assert property ($changed(op_state_o) || $changed(event_enable_o) |->
        ##[1:15] (result_valid_o && result_code_o == 8'h00)) else $error("state change");
endmodule
`default_nettype wire

//--- request_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Requester sending request bytes
module request_source_model (
    // Clock
    input wire logic clk_i,
    // Request stream
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_last_o,
    input wire logic rx_ready_i
);
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_last_o = 1'b0;
    end
    task automatic send(input logic [7:0] m [0:19], input int n, input int gap);
        logic took;
        for (int i = 0; i < n; i++) begin
            rx_valid_o = 1'b1;
            rx_data_o = m[i];
            rx_last_o = (i == n - 1);
            took = 1'b0;
            while (!took) begin
                took = rx_ready_i;
                @(posedge clk_i);
                #1;
            end
            if (gap > 0 || i == n - 1) begin
                rx_valid_o = 1'b0;
                rx_last_o = 1'b0;
                rx_data_o = ~rx_data_o;
                repeat (gap) @(posedge clk_i);
                #(gap > 0 ? 1 : 0);
            end
        end
    endtask
endmodule
`default_nettype wire

//--- state_effecter_enable_cmd_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module state_effecter_enable_cmd_bench;
    localparam logic [15:0] H = 16'h1234;
    logic clk_i = 0, reset_n_i = 0, write_req_i = 0;
    logic [2:0] write_offset_i = 3'h0;
    logic [7:0] write_state_i = 8'h00, eev = 8'h00;
    logic rx_valid_i, rx_last_i, rx_ready_o, result_valid_o, write_done_o, write_refused_o;
    logic [7:0] rx_data_i, result_code_o, event_enable_o, default_restore_o;
    logic [63:0] op_state_o, effecter_state_o, eop = {8{8'h01}};
    int fails = 0, tests_run = 0, gap = 0;
    logic [7:0] rst_seen = 8'h00;
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) rst_seen <= rst_seen | default_restore_o;
    request_source_model src (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .rx_last_o(rx_last_i), .rx_ready_i(rx_ready_o));
    state_effecter_enable_cmd uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .own_handle_i(H),
        .has_default_i(8'h04), .default_state_i(64'h5a_0000), .rx_valid_i(rx_valid_i),
        .rx_data_i(rx_data_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
        .result_valid_o(result_valid_o), .result_code_o(result_code_o),
        .write_req_i(write_req_i), .write_offset_i(write_offset_i),
        .write_state_i(write_state_i), .write_done_o(write_done_o),
        .write_refused_o(write_refused_o), .op_state_o(op_state_o),
        .event_enable_o(event_enable_o), .effecter_state_o(effecter_state_o),
        .default_restore_o(default_restore_o));
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("BAD %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic req(input [15:0] h, input [7:0] cnt, input int n, input [63:0] ops,
        input [63:0] evs, input [7:0] exp);
        logic [7:0] m [0:19];
        int k;
        m[0] = h[7:0];
        m[1] = h[15:8];
        m[2] = cnt;
        for (int i = 0; i < n; i++) begin
            m[3 + 2 * i] = ops[8 * i +: 8];
            m[4 + 2 * i] = evs[8 * i +: 8];
        end
        src.send(m, 3 + 2 * n, gap);
        k = 0;
        while (result_valid_o !== 1'b1 && k < 40) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        check(result_valid_o, 1'b1);
        check(result_code_o, exp);
        for (int i = 0; i < n && exp == 8'h00; i++) begin
            eop[8 * i +: 8] = ops[8 * i +: 8];
            if (evs[8 * i +: 8] != 8'hff) eev[i] = (evs[8 * i +: 8] == 8'h00);
        end
        check(op_state_o, eop);
        check(event_enable_o, eev);
    endtask
    task automatic wr(input [2:0] off, input [7:0] v, input logic refused);
        write_req_i = 1'b1;
        write_offset_i = off;
        write_state_i = v;
        @(posedge clk_i);
        #1;
        write_req_i = 1'b0;
        check(write_refused_o, refused);
        check(write_done_o, !refused);
        @(posedge clk_i);
        #1;
        if (!refused) check(effecter_state_o[8 * off +: 8], v);
    endtask
    task end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100us;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        check(op_state_o, eop);
        check(event_enable_o, 8'h00);
        check(rx_ready_o, 1'b1);
        req(H, 8'h01, 1, 64'h01, 64'h00, 8'h00);
        req(H, 8'h02, 2, 64'h0302, 64'h01ff, 8'h00);
        wr(3'h0, 8'h11, 1'b1);
        wr(3'h1, 8'h22, 1'b0);
        wr(3'h2, 8'h33, 1'b0);
        req(H, 8'h03, 3, 64'h02_0302, 64'hff_ffff, 8'h00);
        check(effecter_state_o[23:16], 8'h5a);
        check(rst_seen, 8'h04);
        req(16'h4321, 8'h01, 1, 64'h01, 64'h00, 8'h80);
        req(16'h0000, 8'h01, 1, 64'h01, 64'h00, 8'h80);
        req(16'hffff, 8'h01, 1, 64'h01, 64'h00, 8'h80);
        req(H, 8'h00, 0, 64'h00, 64'h00, 8'h02);
        req(H, 8'h09, 8, {8{8'h01}}, 64'h00, 8'h02);
        req(H, 8'h02, 1, 64'h01, 64'h00, 8'h02);
        req(H, 8'h01, -1, 64'h00, 64'h00, 8'h02);
        req(H, 8'h01, 1, 64'h04, 64'h00, 8'h02);
        req(H, 8'h01, 1, 64'h01, 64'h05, 8'h02);
        gap = 1;
        req(H, 8'h08, 8, {8{8'h01}}, 64'h00ff_0100_ff01_00ff, 8'h00);
        wr(3'h0, 8'h44, 1'b0);
        wr(3'h7, 8'h55, 1'b0);
        end_of_test();
    end
endmodule
bind state_effecter_enable_cmd state_effecter_enable_cmd_chk chk (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i),
    .rx_ready_o(rx_ready_o), .result_valid_o(result_valid_o), .result_code_o(result_code_o),
    .write_req_i(write_req_i), .write_offset_i(write_offset_i), .write_done_o(write_done_o),
    .write_refused_o(write_refused_o), .op_state_o(op_state_o),
    .event_enable_o(event_enable_o));
`default_nettype wire
